// file: pkg/rsid_map.svh
/*
 * Register offsets, field positions, reset values and setting codes of the
 * remote signal input defaulting block.
 * Assumes byte addressing on a 32-bit Avalon-MM slave, one word per register.
 */
`ifndef RSID_MAP_SVH
`define RSID_MAP_SVH

`define RSID_ADDR_W 6
`define RSID_OFS_CTRL 6'h00
`define RSID_OFS_TP1_FB 6'h04
`define RSID_OFS_TP2_FB 6'h08
`define RSID_OFS_STATUS 6'h0c
`define RSID_OFS_MASK 6'h10
`define RSID_OFS_TP_STATE 6'h14
`define RSID_OFS_TP_SEEN 6'h18
`define RSID_OFS_DI_STATE 6'h1c
`define RSID_OFS_DI_SEEN 6'h20
`define RSID_OFS_RELAY_EN 6'h24
`define RSID_OFS_CFG_INDEX 6'h28
`define RSID_OFS_CFG_DATA 6'h2c

`define RSID_CTRL_TP_EN 0
`define RSID_CTRL_TWO_CH 1
`define RSID_CTRL_W 2
`define RSID_CTRL_RST 2'h0

`define RSID_EV_CH1_FAIL 0
`define RSID_EV_CH2_FAIL 1
`define RSID_EV_CH1_RESTORE 2
`define RSID_EV_CH2_RESTORE 3
`define RSID_EV_DEV_OFFLINE 4
`define RSID_EV_DEV_ONLINE 5
`define RSID_EV_W 6

`define RSID_FB_OFF 2'h0
`define RSID_FB_ON 2'h1
`define RSID_FB_LATEST_OFF 2'h2
`define RSID_FB_LATEST_ON 2'h3

`define RSID_NUM_TP 16
`define RSID_NUM_DIRECT 32
`define RSID_DIR_IDX_W 5
`define RSID_DEV_IDX_W 4
`define RSID_CFG_W 16

`endif

// file: pkg/rsid_pkg.sv
/*
 * Types and shared functions of the remote signal input defaulting block.
 * Assumes rsid_map.svh is on the include path.
 */
`include "rsid_map.svh"

package rsid_pkg;

	typedef enum logic [1:0] {
		RSID_FB_OFF_MODE = `RSID_FB_OFF,
		RSID_FB_ON_MODE = `RSID_FB_ON,
		RSID_FB_LATEST_OFF_MODE = `RSID_FB_LATEST_OFF,
		RSID_FB_LATEST_ON_MODE = `RSID_FB_LATEST_ON
	} rsid_fallback_type;

	typedef enum logic [1:0] {
		RSID_BUS_IDLE = 2'h0,
		RSID_BUS_FETCH = 2'h1,
		RSID_BUS_DONE = 2'h3
	} rsid_bus_state_type;

	typedef struct packed {
		rsid_fallback_type fallback;
		logic [`RSID_DEV_IDX_W-1:0] src_dev;
		logic [`RSID_DIR_IDX_W-1:0] bit_num;
		logic [`RSID_DIR_IDX_W-1:0] relay_src;
	} rsid_di_cfg_type;

	typedef struct packed {
		logic read;
		logic write;
		logic [`RSID_ADDR_W-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} rsid_avs_req_type;

	// Value an input takes while its source is failed or offline.
	function automatic logic rsid_fallback_value(input logic [1:0] code, input logic seen, input logic last);
		logic v;
		v = 1'b0;
		case (code)
			`RSID_FB_ON: v = 1'b1;
			`RSID_FB_LATEST_OFF: v = seen ? last : 1'b0;
			`RSID_FB_LATEST_ON: v = seen ? last : 1'b1;
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	function automatic logic [31:0] rsid_merge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[b*8 +: 8] = din[b*8 +: 8];
		end
		return r;
	endfunction

endpackage

// file: design/rsid_cfg_mem.sv
/*
 * Setting store for the direct inputs: one write port and two read ports,
 * each read port with registered data one cycle after its address.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module rsid_cfg_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_data,
	input wire logic [AW-1:0] i_a_addr,
	output logic [WIDTH-1:0] o_a_data,
	input wire logic [AW-1:0] i_b_addr,
	output logic [WIDTH-1:0] o_b_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Cleared on reset so every input starts forced low with a known source.
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			for (int k = 0; k < DEPTH; k++)
				mem[k] <= '0;
			o_a_data <= '0;
			o_b_data <= '0;
		end
		else
		begin
			if (i_wr_en)
				mem[i_wr_addr] <= i_wr_data;
			o_a_data <= mem[i_a_addr];
			o_b_data <= mem[i_b_addr];
		end
	end
endmodule // rsid_cfg_mem

`default_nettype wire

// file: design/rsid_fallback_bank.sv
/*
 * One teleprotection channel: passes received bits while the channel is
 * healthy and applies each input's fallback while it has failed.
 * Assumes channel health and received bits are synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module rsid_fallback_bank #(
	parameter int N = 16
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_enable,
	input wire logic i_ok,
	input wire logic [N-1:0] i_rx,
	input wire logic [2*N-1:0] i_fallback,
	output logic [N-1:0] o_state,
	output logic [N-1:0] o_seen
);
	import rsid_pkg::*;

	logic [N-1:0] last;

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			last <= '0;
			o_seen <= '0;
			o_state <= '0;
		end
		else if (!i_enable)
			o_state <= '0;
		else if (i_ok)
		begin
			last <= i_rx;
			o_seen <= '1;
			o_state <= i_rx;
		end
		else
		begin
			for (int k = 0; k < N; k++)
				o_state[k] <= rsid_fallback_value(i_fallback[2*k +: 2], o_seen[k], last[k]);
		end
	end
endmodule // rsid_fallback_bank

`default_nettype wire

// file: design/rsid_top.sv
/*
 * Remote signal input defaulting: teleprotection inputs on two channels and
 * direct inputs picked from peer messages, each with a fallback state, plus
 * relaying of direct inputs onto direct outputs, behind an Avalon-MM slave.
 * Assumes all link inputs are synchronous to i_clk and that peer framing is
 * done upstream.
 */
// Our own choices: the register addresses and register access over Avalon-MM.
// Function
// - Sixteen teleprotection inputs from channel one.
// - Channel two inputs only in two-channel configurations.
// - Teleprotection inputs carry nothing while disabled.
// - Forced-high fallback drives one on failure.
// - Forced-low fallback drives zero on failure.
// - Hold-last modes freeze last received state.
// - Never received: hold-last falls back one/zero.
// - Direct input picks selected bit from device.
// - Direct outputs may relay received direct inputs.
// - Restored communication passes received states again.
// - Offline source device applies direct fallback.
// - Bit number equals sender's direct output index.
`timescale 1ns/1ps
`default_nettype none
`include "rsid_map.svh"

module rsid_top #(
	parameter int NDEV = 16
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire rsid_pkg::rsid_avs_req_type i_avs,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq,
	input wire logic i_tp1_ok,
	input wire logic [`RSID_NUM_TP-1:0] i_tp1_rx,
	input wire logic i_tp2_ok,
	input wire logic [`RSID_NUM_TP-1:0] i_tp2_rx,
	output logic [`RSID_NUM_TP-1:0] o_tp1,
	output logic [`RSID_NUM_TP-1:0] o_tp2,
	input wire logic [NDEV-1:0] i_dev_online,
	input wire logic [NDEV-1:0][`RSID_NUM_DIRECT-1:0] i_dev_msg,
	input wire logic [`RSID_NUM_DIRECT-1:0] i_local_dout,
	output logic [`RSID_NUM_DIRECT-1:0] o_direct_in,
	output logic [`RSID_NUM_DIRECT-1:0] o_direct_out
);
	import rsid_pkg::*;

	localparam int NDIR = `RSID_NUM_DIRECT;
	localparam int NTP = `RSID_NUM_TP;
	localparam int IW = `RSID_DIR_IDX_W;

	// Software-visible registers.
	logic [`RSID_CTRL_W-1:0] ctrl;
	logic [31:0] tp1_fb;
	logic [31:0] tp2_fb;
	logic [`RSID_EV_W-1:0] status;
	logic [`RSID_EV_W-1:0] mask;
	logic [NDIR-1:0] relay_en;
	logic [IW-1:0] cfg_index;
	logic [31:0] readdata;
	rsid_bus_state_type bus_state;
	rsid_bus_state_type next_bus_state;

	// Link-side state.
	logic tp1_ok_q;
	logic tp2_ok_q;
	logic [NDEV-1:0] online_q;
	logic [NTP-1:0] tp1_seen;
	logic [NTP-1:0] tp2_seen;
	logic [NDIR-1:0] di_last;
	logic [NDIR-1:0] di_seen;
	logic [NDIR-1:0] relay_val;
	logic [IW-1:0] scan_idx;
	logic [IW-1:0] scan_idx_d;
	logic [`RSID_CFG_W-1:0] mem_a_q;
	logic [`RSID_CFG_W-1:0] mem_b_q;

	// Address decode.
	wire idle = (bus_state == RSID_BUS_IDLE);
	wire wr = i_avs.write & idle;
	wire hit_ctrl = (i_avs.address == `RSID_OFS_CTRL);
	wire hit_tp1_fb = (i_avs.address == `RSID_OFS_TP1_FB);
	wire hit_tp2_fb = (i_avs.address == `RSID_OFS_TP2_FB);
	wire hit_status = (i_avs.address == `RSID_OFS_STATUS);
	wire hit_mask = (i_avs.address == `RSID_OFS_MASK);
	wire hit_tp_state = (i_avs.address == `RSID_OFS_TP_STATE);
	wire hit_tp_seen = (i_avs.address == `RSID_OFS_TP_SEEN);
	wire hit_di_state = (i_avs.address == `RSID_OFS_DI_STATE);
	wire hit_di_seen = (i_avs.address == `RSID_OFS_DI_SEEN);
	wire hit_relay_en = (i_avs.address == `RSID_OFS_RELAY_EN);
	wire hit_cfg_index = (i_avs.address == `RSID_OFS_CFG_INDEX);
	wire hit_cfg_data = (i_avs.address == `RSID_OFS_CFG_DATA);

	// Reads take two wait cycles so that the setting memory and every
	// readback pass through a register before they reach the bus.
	assign o_avs_waitrequest = i_avs.read & (bus_state != RSID_BUS_DONE);
	assign o_avs_readdata = readdata;

	// A read walks idle, fetch, done; writes never leave idle.
	always_comb
	begin
		case (bus_state)
			RSID_BUS_IDLE: next_bus_state = i_avs.read ? RSID_BUS_FETCH : RSID_BUS_IDLE;
			RSID_BUS_FETCH: next_bus_state = RSID_BUS_DONE;
			RSID_BUS_DONE: next_bus_state = RSID_BUS_IDLE;
			default: next_bus_state = RSID_BUS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			bus_state <= RSID_BUS_IDLE;
		else
			bus_state <= next_bus_state;
	end

	wire [31:0] wdata = i_avs.writedata;
	wire [3:0] be = i_avs.byteenable;
	wire [31:0] ctrl_w = rsid_merge({{(32-`RSID_CTRL_W){1'b0}}, ctrl}, wdata, be);
	wire [31:0] tp1_fb_w = rsid_merge(tp1_fb, wdata, be);
	wire [31:0] tp2_fb_w = rsid_merge(tp2_fb, wdata, be);
	wire [31:0] mask_w = rsid_merge({{(32-`RSID_EV_W){1'b0}}, mask}, wdata, be);
	wire [31:0] relay_w = rsid_merge(relay_en, wdata, be);
	wire [31:0] index_w = rsid_merge({{(32-IW){1'b0}}, cfg_index}, wdata, be);
	wire [31:0] clear_w = rsid_merge(32'h0, wdata, be);
	wire cfg_wr = wr & hit_cfg_data & (be[1:0] == 2'h3);

	wire tp_en = ctrl[`RSID_CTRL_TP_EN];
	wire two_ch = ctrl[`RSID_CTRL_TWO_CH];

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ctrl <= `RSID_CTRL_RST;
			tp1_fb <= 32'h0;
			tp2_fb <= 32'h0;
		end
		else if (wr)
		begin
			if (hit_ctrl)
				ctrl <= ctrl_w[`RSID_CTRL_W-1:0];
			if (hit_tp1_fb)
				tp1_fb <= tp1_fb_w;
			if (hit_tp2_fb)
				tp2_fb <= tp2_fb_w;
		end
	end

	// Relay enables and the setting index; a new index applies to the next
	// setting access, so software writes the index before the data.
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			relay_en <= '0;
			cfg_index <= '0;
		end
		else if (wr)
		begin
			if (hit_relay_en)
				relay_en <= relay_w;
			if (hit_cfg_index)
				cfg_index <= index_w[IW-1:0];
		end
	end

	// The interrupt line is built from next values, so a mask write takes
	// effect on the same edge as the register itself.
	wire [`RSID_EV_W-1:0] next_mask = (wr & hit_mask) ? mask_w[`RSID_EV_W-1:0] : mask;

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			mask <= '0;
		else
			mask <= next_mask;
	end

	// Readback, selected during the fetch cycle; unmapped offsets read zero.
	wire [31:0] rd_value =
		hit_ctrl ? {{(32-`RSID_CTRL_W){1'b0}}, ctrl} :
		hit_tp1_fb ? tp1_fb :
		hit_tp2_fb ? tp2_fb :
		hit_status ? {{(32-`RSID_EV_W){1'b0}}, status} :
		hit_mask ? {{(32-`RSID_EV_W){1'b0}}, mask} :
		hit_tp_state ? {o_tp2, o_tp1} :
		hit_tp_seen ? {tp2_seen, tp1_seen} :
		hit_di_state ? o_direct_in :
		hit_di_seen ? di_seen :
		hit_relay_en ? relay_en :
		hit_cfg_index ? {{(32-IW){1'b0}}, cfg_index} :
		hit_cfg_data ? {{(32-`RSID_CFG_W){1'b0}}, mem_a_q} : 32'h0;

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			readdata <= 32'h0;
		else if (bus_state == RSID_BUS_FETCH)
			readdata <= rd_value;
	end

	// Teleprotection channels.
	rsid_fallback_bank #(
		.N(NTP)
	) u_tp1 (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_enable(tp_en),
		.i_ok(i_tp1_ok),
		.i_rx(i_tp1_rx),
		.i_fallback(tp1_fb),
		.o_state(o_tp1),
		.o_seen(tp1_seen)
	);

	rsid_fallback_bank #(
		.N(NTP)
	) u_tp2 (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_enable(tp_en & two_ch),
		.i_ok(i_tp2_ok),
		.i_rx(i_tp2_rx),
		.i_fallback(tp2_fb),
		.o_state(o_tp2),
		.o_seen(tp2_seen)
	);

	// Direct input settings, scanned round-robin by port B.
	rsid_cfg_mem #(
		.WIDTH(`RSID_CFG_W),
		.DEPTH(NDIR),
		.AW(IW)
	) u_cfg (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_wr_en(cfg_wr),
		.i_wr_addr(cfg_index),
		.i_wr_data(wdata[`RSID_CFG_W-1:0]),
		.i_a_addr(cfg_index),
		.o_a_data(mem_a_q),
		.i_b_addr(scan_idx),
		.o_b_data(mem_b_q)
	);

	// Each direct input is refreshed once every NDIR cycles; the trade is
	// one memory instead of NDIR parallel selectors, at 256 ns worst lag.
	rsid_di_cfg_type cfg;
	assign cfg = rsid_di_cfg_type'(mem_b_q);
	wire src_valid = (32'(cfg.src_dev) < NDEV);
	wire src_online = src_valid & i_dev_online[cfg.src_dev];
	wire src_bit = i_dev_msg[cfg.src_dev][cfg.bit_num];
	wire fb_bit = rsid_fallback_value(cfg.fallback, di_seen[scan_idx_d], di_last[scan_idx_d]);

	// The delayed index lines up with the memory's registered read data.
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			scan_idx <= '0;
			scan_idx_d <= '0;
		end
		else
		begin
			scan_idx <= scan_idx + 1'b1;
			scan_idx_d <= scan_idx;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			di_last <= '0;
			di_seen <= '0;
			o_direct_in <= '0;
			relay_val <= '0;
		end
		else
		begin
			relay_val[scan_idx_d] <= o_direct_in[cfg.relay_src];
			if (src_online)
			begin
				di_last[scan_idx_d] <= src_bit;
				di_seen[scan_idx_d] <= 1'b1;
				o_direct_in[scan_idx_d] <= src_bit;
			end
			else
				o_direct_in[scan_idx_d] <= fb_bit;
		end
	end

	// Direct outputs: local operand unless relaying is enabled for that bit.
	wire [NDIR-1:0] next_direct_out = (relay_en & relay_val) | (~relay_en & i_local_dout);

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			o_direct_out <= '0;
		else
			o_direct_out <= next_direct_out;
	end

	// Events: channel failure and restoration, device offline and online.
	logic [`RSID_EV_W-1:0] events;
	always_comb
	begin
		events = '0;
		events[`RSID_EV_CH1_FAIL] = tp1_ok_q & ~i_tp1_ok;
		events[`RSID_EV_CH2_FAIL] = tp2_ok_q & ~i_tp2_ok;
		events[`RSID_EV_CH1_RESTORE] = ~tp1_ok_q & i_tp1_ok;
		events[`RSID_EV_CH2_RESTORE] = ~tp2_ok_q & i_tp2_ok;
		events[`RSID_EV_DEV_OFFLINE] = |(online_q & ~i_dev_online);
		events[`RSID_EV_DEV_ONLINE] = |(~online_q & i_dev_online);
	end

	// A new event in the cycle of its clear keeps the bit set.
	wire [`RSID_EV_W-1:0] clear_bits = (wr & hit_status) ? clear_w[`RSID_EV_W-1:0] : '0;
	wire [`RSID_EV_W-1:0] next_status = (status & ~clear_bits) | events;

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			status <= '0;
			o_irq <= 1'b0;
		end
		else
		begin
			status <= next_status;
			o_irq <= |(next_status & next_mask);
		end
	end

	// Registered link health; every event is an edge against it, and its
	// reset value makes the first healthy link after reset log a restore.
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			tp1_ok_q <= 1'b0;
			tp2_ok_q <= 1'b0;
			online_q <= '0;
		end
		else
		begin
			tp1_ok_q <= i_tp1_ok;
			tp2_ok_q <= i_tp2_ok;
			online_q <= i_dev_online;
		end
	end
endmodule // rsid_top

`default_nettype wire

// file: verif/rsid_top_properties.sv
/*
 * Timing checks on the register bus and teleprotection ports of rsid_top.
 * Assumes it sees only the top module's ports, through the bind below.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rsid_map.svh"

module rsid_top_properties (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire rsid_pkg::rsid_avs_req_type i_avs,
	input wire logic o_avs_waitrequest,
	input wire logic o_irq,
	input wire logic i_tp1_ok,
	input wire logic [`RSID_NUM_TP-1:0] i_tp1_rx,
	input wire logic i_tp2_ok,
	input wire logic [`RSID_NUM_TP-1:0] i_tp2_rx,
	input wire logic [`RSID_NUM_TP-1:0] o_tp1,
	input wire logic [`RSID_NUM_TP-1:0] o_tp2
);
	import rsid_pkg::*;

	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	sequence s_read_start;
		i_avs.read && !$past(i_avs.read);
	endsequence
	sequence s_two_waits;
		o_avs_waitrequest [*2] ##1 !o_avs_waitrequest;
	endsequence

	property p_write_no_wait;
		i_avs.write |-> !o_avs_waitrequest;
	endproperty
	a_write_no_wait: assert property (p_write_no_wait) else $error("write stalled");
	property p_idle_no_wait;
		!i_avs.read |-> !o_avs_waitrequest;
	endproperty
	a_idle_no_wait: assert property (p_idle_no_wait) else $error("wait without read");
	property p_read_wait;
		s_read_start |-> s_two_waits;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait length wrong");
	property p_tp1_pass;
		i_tp1_ok |=> o_tp1 == $past(i_tp1_rx) || o_tp1 == '0;
	endproperty
	a_tp1_pass: assert property (p_tp1_pass) else $error("ch1 not passed");
	property p_tp2_pass;
		i_tp2_ok |=> o_tp2 == $past(i_tp2_rx) || o_tp2 == '0;
	endproperty
	a_tp2_pass: assert property (p_tp2_pass) else $error("ch2 not passed");
	// Settings writes are excluded because they may legally change the fallback.
	property p_tp1_hold;
		(!i_tp1_ok && !i_avs.write) [*2] |=> $stable(o_tp1);
	endproperty
	a_tp1_hold: assert property (p_tp1_hold) else $error("ch1 fallback moved");
	property p_tp2_hold;
		(!i_tp2_ok && !i_avs.write) [*2] |=> $stable(o_tp2);
	endproperty
	a_tp2_hold: assert property (p_tp2_hold) else $error("ch2 fallback moved");
	property p_reset_clear;
		@(posedge i_clk) disable iff (1'b0) i_reset |=> o_tp1 == '0 && o_tp2 == '0 && !o_irq;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
endmodule // rsid_top_properties

bind rsid_top rsid_top_properties rsid_top_properties_inst (
	.i_clk(i_clk),
	.i_reset(i_reset),
	.i_avs(i_avs),
	.o_avs_waitrequest(o_avs_waitrequest),
	.o_irq(o_irq),
	.i_tp1_ok(i_tp1_ok),
	.i_tp1_rx(i_tp1_rx),
	.i_tp2_ok(i_tp2_ok),
	.i_tp2_rx(i_tp2_rx),
	.o_tp1(o_tp1),
	.o_tp2(o_tp2)
);

`default_nettype wire

// file: verif/rsid_peer.sv
/*
 * Peer relay model: teleprotection bits on two channels and direct output
 * words of NDEV devices. Assumes the bench sets what is sent and which links are up.
 */
`timescale 1ns/1ps
`default_nettype none

module rsid_peer #(
	parameter int NDEV = 16
) (
	input wire logic i_clk,
	input wire logic [1:0] i_link_up,
	input wire logic i_slow,
	input wire logic [15:0] i_tx1,
	input wire logic [15:0] i_tx2,
	input wire logic [NDEV-1:0] i_dev_up,
	input wire logic [NDEV-1:0][31:0] i_dev_out,
	output logic o_ok1,
	output logic [15:0] o_rx1,
	output logic o_ok2,
	output logic [15:0] o_rx2,
	output logic [NDEV-1:0] o_online,
	output logic [NDEV-1:0][31:0] o_msg
);
	logic [15:0] late1;
	logic [15:0] late2;

	// A lost link carries nothing trustworthy, so the lines show the inverse.
	always_ff @(posedge i_clk)
	begin
		late1 <= i_tx1;
		late2 <= i_tx2;
		o_ok1 <= i_link_up[0];
		o_ok2 <= i_link_up[1];
		o_rx1 <= i_link_up[0] ? (i_slow ? late1 : i_tx1) : ~i_tx1;
		o_rx2 <= i_link_up[1] ? (i_slow ? late2 : i_tx2) : ~i_tx2;
		o_online <= i_dev_up;
		for (int i = 0; i < NDEV; i++)
			o_msg[i] <= i_dev_up[i] ? i_dev_out[i] : ~i_dev_out[i];
	end
endmodule // rsid_peer

`default_nettype wire

// file: verif/rsid_top_bench.sv
/*
 * Self-checking bench of rsid_top with a peer relay model on its links.
 * Assumes the checker binds itself to rsid_top.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rsid_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end

module rsid_top_bench;
	import rsid_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	rsid_avs_req_type avs = '0;
	logic [31:0] rdata, q, din, dout;
	logic [31:0] ldout = '0;
	logic wreq, irq, ok1, ok2, wq, slow = 1'b0;
	logic [15:0] rx1, rx2, tp1, tp2, e, online, tx1 = '0, tx2 = '0, dev_up = '0;
	logic [1:0] link_up = '0;
	logic [15:0][31:0] msg;
	logic [15:0][31:0] dev_out = '0;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;

	rsid_top rsid_top_inst (.i_clk(clk), .i_reset(rst), .i_avs(avs), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .o_irq(irq), .i_tp1_ok(ok1), .i_tp1_rx(rx1), .i_tp2_ok(ok2),
		.i_tp2_rx(rx2), .o_tp1(tp1), .o_tp2(tp2), .i_dev_online(online), .i_dev_msg(msg),
		.i_local_dout(ldout), .o_direct_in(din), .o_direct_out(dout));
	rsid_peer rsid_peer_inst (.i_clk(clk), .i_link_up(link_up), .i_slow(slow), .i_tx1(tx1),
		.i_tx2(tx2), .i_dev_up(dev_up), .i_dev_out(dev_out), .o_ok1(ok1), .o_rx1(rx1),
		.o_ok2(ok2), .o_rx2(rx2), .o_online(online), .o_msg(msg));

	always #4 clk = ~clk;
	// Waitrequest is captured mid-cycle so the rising edge sees a settled value.
	always @(negedge clk) wq = wreq;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic final_report;
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
		avs <= '{!w, w, a, d, 4'hf};
		@(posedge clk);
		while (wq !== 1'b0)
			@(posedge clk);
		q = rdata;
		avs <= '0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		`CHK(nm, x, q)
	endtask

	task automatic s_reset;
		rd_chk("ctrl", `RSID_OFS_CTRL, 32'h0);
		rd_chk("tp seen", `RSID_OFS_TP_SEEN, 32'h0);
		rd_chk("unmapped", 6'h3c, 32'h0);
		rd_chk("unaligned", 6'h01, 32'h0);
		`CHK("tp1 idle", 16'h0, tp1)
	endtask

	task automatic s_tp;
		wr(`RSID_OFS_TP1_FB, 32'he4e4e4e4);
		wr(`RSID_OFS_CTRL, 32'h1);
		tick(4);
		`CHK("never seen", 16'haaaa, tp1)
		tx1 <= 16'h5a3c;
		tx2 <= 16'h00ff;
		link_up <= 2'h3;
		tick(4);
		`CHK("pass", 16'h5a3c, tp1)
		`CHK("ch2 off", 16'h0, tp2)
		rd_chk("tp seen", `RSID_OFS_TP_SEEN, 32'hffff);
		wr(`RSID_OFS_CTRL, 32'h3);
		tick(4);
		`CHK("ch2", 16'h00ff, tp2)
		wr(`RSID_OFS_STATUS, 32'h3f);
		link_up <= 2'h2;
		tick(4);
		for (int k = 0; k < 16; k++)
			e[k] = (k % 4 == 0) ? 1'b0 : (k % 4 == 1) ? 1'b1 : tx1[k];
		`CHK("frozen", e, tp1)
		rd_chk("status", `RSID_OFS_STATUS, 32'h1);
		`CHK("masked irq", 1'b0, irq)
		wr(`RSID_OFS_MASK, 32'h1);
		`CHK("irq", 1'b1, irq)
		wr(`RSID_OFS_STATUS, 32'h1);
		`CHK("irq cleared", 1'b0, irq)
		slow <= 1'b1;
		tx1 <= 16'h0f0f;
		link_up <= 2'h3;
		tick(5);
		`CHK("resumed", 16'h0f0f, tp1)
		wr(`RSID_OFS_CTRL, 32'h0);
		tick(2);
		`CHK("disabled", 32'h0, {tp2, tp1})
	endtask

	task automatic s_direct;
		dev_out[1] <= 32'h800;
		dev_up <= 16'h2;
		ldout <= 32'hf0;
		wr(`RSID_OFS_CFG_INDEX, 32'h5);
		wr(`RSID_OFS_CFG_DATA, {16'h0, 2'h1, 4'h1, 5'hb, 5'h0});
		wr(`RSID_OFS_CFG_INDEX, 32'h3);
		wr(`RSID_OFS_CFG_DATA, 32'h5);
		wr(`RSID_OFS_RELAY_EN, 32'h8);
		tick(80);
		`CHK("picked", 1'b1, din[5])
		`CHK("relayed", 1'b1, dout[3])
		`CHK("local", 4'hf, dout[7:4])
		`CHK("permit", 1'b0, din[5] & din[6])
		rd_chk("di seen", `RSID_OFS_DI_SEEN, 32'h20);
		dev_out[1] <= 32'h0;
		tick(80);
		`CHK("follows", 1'b0, din[5])
		dev_up <= 16'h0;
		tick(80);
		`CHK("offline", 1'b1, din[5])
		`CHK("relay fb", 1'b1, dout[3])
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		s_reset();
		s_tp();
		s_direct();
		final_report();
	end
endmodule // rsid_top_bench

`default_nettype wire
